// ### hdl/sync_cfg_pkg.sv
// Constants for the sync timing and copy-protection configuration bank.
// How it works
// - End-of-vertical-blank line register, 8 bits, resets to 12h.
// - 525-line: blanking ends on line n+5 odd, n+268 even fields.
// - A 9-bit start line asserts blanking; blanking spans start to end.
// - End-of-line-sync register, 8 bits, resets to 30h.
// - Line sync end spans 0 to 510 double-rate counts, two per step.
// - Horizontal count is zero at the line sync leading edge.
// - Sync acceptance window width register, 8 bits, resets to 20h.
// - The window is centred on the expected sync position.
// - Sync inside the window keeps normal locked timing.
// - Sync outside the window enters acquisition using external mode bits.
// - Control bit 7 enables colour-stripe detection; clear freezes its status.
// - Control bit 6 enables pseudo-sync detection; clear freezes its status.
// - Bits 5-3 give extra sync pulses needed; reset 100b.
// - Pseudo-sync must also persist the minimum field count.
// - Bits 2-0 plus two give minimum persistence fields; reset 110b.
package sync_cfg_pkg;
	localparam logic [7:0] VBLANK_END_ADDR = 8'h35;
	localparam logic [7:0] LSYNC_END_ADDR = 8'h36;
	localparam logic [7:0] WINDOW_ADDR = 8'h37;
	localparam logic [7:0] CP_CTRL_ADDR = 8'h41;
	localparam logic [7:0] VBLANK_END_RESET = 8'h12;
	localparam logic [7:0] LSYNC_END_RESET = 8'h30;
	localparam logic [7:0] WINDOW_RESET = 8'h20;
	localparam logic [7:0] CP_CTRL_RESET = 8'h26;
	localparam int STRIPE_EN_BIT = 7;
	localparam int PSP_EN_BIT = 6;
	localparam int PSP_COUNT_LSB = 3;
	localparam int FIELD_COUNT_LSB = 0;
	localparam logic [3:0] FIELD_COUNT_ADD = 4'h2;
	localparam logic [9:0] ODD_FIELD_OFFSET = 10'h005;
	localparam logic [9:0] EVEN_525_OFFSET = 10'h10C;
	localparam logic [9:0] EVEN_625_OFFSET = 10'h13E;
	// Double-rate counts per scan line; a plain default for the line timebase.
	localparam logic [10:0] LINE_CLOCKS = 11'h6B4;
	localparam logic [9:0] FIRST_LINE = 10'h001;
endpackage

// ### hdl/sync_cfg.sv
// Sync timing, acquisition window and copy-protection qualification bank.
module sync_cfg
	import sync_cfg_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic odd_field_in,
	input wire logic lines_625_in,
	input wire logic [8:0] vblank_start_line_in,
	input wire logic [1:0] lock_mode_in,
	input wire logic stripe_seen_in,
	input wire logic extra_pulse_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic line_sync_out,
	output logic vblank_out,
	output logic acquiring_out,
	output logic [1:0] acquire_mode_out,
	output logic stripe_detected_out,
	output logic pseudo_sync_detected_out
);
	// Register file.
	logic [7:0] vblank_end, next_vblank_end;
	logic [7:0] lsync_end, next_lsync_end;
	logic [7:0] window, next_window;
	logic [7:0] cp_ctrl, next_cp_ctrl;
	logic [7:0] next_rdata;
	logic next_rvalid;

	// Line timebase.
	logic [10:0] hcount, next_hcount;
	logic [9:0] line_num, next_line_num;
	logic hsync_prev, vsync_prev;
	logic next_line_sync, next_vblank, next_acquiring;
	logic [1:0] next_acq_mode;
	logic hs_edge, vs_edge, in_window;
	logic [9:0] even_off, off, start_tgt, end_tgt;

	// Copy-protection qualification.
	logic [3:0] stripe_cnt, next_stripe_cnt;
	logic [3:0] psp_cnt, next_psp_cnt;
	logic [3:0] extra_cnt, next_extra_cnt;
	logic next_stripe_det, next_psp_det;
	logic [3:0] need_fields;
	logic psp_present;

	// Distance in double-rate counts from the expected sync position at count zero.
	function automatic logic [10:0] sync_distance(input logic [10:0] h);
		logic [10:0] back;
		back = LINE_CLOCKS - h;
		return (h < back) ? h : back;
	endfunction

	// One field of persistence filtering: the status flips only after the
	// opposite condition has been seen for the required number of fields.
	function automatic logic [4:0] persist_step(input logic status, input logic seen,
			input logic [3:0] cnt, input logic [3:0] need);
		logic [3:0] inc;
		inc = (cnt == 4'hF) ? cnt : cnt + 4'h1;
		if (seen == status) begin
			return {status, 4'h0};
		end
		if (inc >= need) begin
			return {seen, 4'h0};
		end
		return {status, inc};
	endfunction

	// Register writes and read-back; unmapped sub-addresses read as zero.
	always_comb begin
		next_vblank_end = vblank_end;
		next_lsync_end = lsync_end;
		next_window = window;
		next_cp_ctrl = cp_ctrl;
		next_rdata = reg_rdata_out;
		next_rvalid = reg_read_in;
		if (reg_write_in) begin
			unique case (reg_addr_in)
				VBLANK_END_ADDR: next_vblank_end = reg_wdata_in;
				LSYNC_END_ADDR: next_lsync_end = reg_wdata_in;
				WINDOW_ADDR: next_window = reg_wdata_in;
				CP_CTRL_ADDR: next_cp_ctrl = reg_wdata_in;
				default: next_cp_ctrl = cp_ctrl;
			endcase
		end
		if (reg_read_in) begin
			unique case (reg_addr_in)
				VBLANK_END_ADDR: next_rdata = vblank_end;
				LSYNC_END_ADDR: next_rdata = lsync_end;
				WINDOW_ADDR: next_rdata = window;
				CP_CTRL_ADDR: next_rdata = cp_ctrl;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vblank_end <= VBLANK_END_RESET;
			lsync_end <= LSYNC_END_RESET;
			window <= WINDOW_RESET;
			cp_ctrl <= CP_CTRL_RESET;
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			vblank_end <= next_vblank_end;
			lsync_end <= next_lsync_end;
			window <= next_window;
			cp_ctrl <= next_cp_ctrl;
			reg_rdata_out <= next_rdata;
			reg_rvalid_out <= next_rvalid;
		end
	end

	// Horizontal lock, line sync and vertical blanking.
	// The window half-width in double-rate counts equals the register value,
	// since the register gives the full width in single-rate samples.
	assign hs_edge = hsync_in && !hsync_prev;
	assign vs_edge = vsync_in && !vsync_prev;
	assign in_window = sync_distance(hcount) <= {3'b000, window};
	assign even_off = lines_625_in ? EVEN_625_OFFSET : EVEN_525_OFFSET;
	assign off = odd_field_in ? ODD_FIELD_OFFSET : even_off;
	assign start_tgt = {1'b0, vblank_start_line_in} + off;
	assign end_tgt = {2'b00, vblank_end} + off;

	always_comb begin
		next_hcount = (hcount == LINE_CLOCKS - 11'h001) ? 11'h000 : hcount + 11'h001;
		next_acquiring = acquiring_out;
		next_acq_mode = acquire_mode_out;
		next_line_num = line_num;
		if (hs_edge) begin
			if (in_window) begin
				next_acquiring = 1'b0;
			end else begin
				// A stray sync re-seeds the timebase so the edge becomes count zero.
				next_acquiring = 1'b1;
				next_acq_mode = lock_mode_in;
				next_hcount = 11'h000;
			end
		end
		if (vs_edge) begin
			next_line_num = FIRST_LINE;
		end else if (next_hcount == 11'h000 && hcount != 11'h000) begin
			next_line_num = line_num + 10'h001;
		end
		// Sync is high from count zero up to twice the register value.
		next_line_sync = next_hcount < {2'b00, lsync_end, 1'b0};
		next_vblank = vblank_out;
		if (next_line_num == end_tgt) begin
			next_vblank = 1'b0;
		end else if (next_line_num == start_tgt) begin
			next_vblank = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hcount <= 11'h000;
			line_num <= FIRST_LINE;
			hsync_prev <= 1'b0;
			vsync_prev <= 1'b0;
			line_sync_out <= 1'b0;
			vblank_out <= 1'b0;
			acquiring_out <= 1'b0;
			acquire_mode_out <= 2'b00;
		end else begin
			hcount <= next_hcount;
			line_num <= next_line_num;
			hsync_prev <= hsync_in;
			vsync_prev <= vsync_in;
			line_sync_out <= next_line_sync;
			vblank_out <= next_vblank;
			acquiring_out <= next_acquiring;
			acquire_mode_out <= next_acq_mode;
		end
	end

	// Copy-protection detection, judged once per field at the field start.
	// A disabled component keeps its status and filter count untouched.
	assign need_fields = {1'b0, cp_ctrl[FIELD_COUNT_LSB +: 3]} + FIELD_COUNT_ADD;
	assign psp_present = extra_cnt >= {1'b0, cp_ctrl[PSP_COUNT_LSB +: 3]};

	always_comb begin
		next_stripe_det = stripe_detected_out;
		next_stripe_cnt = stripe_cnt;
		next_psp_det = pseudo_sync_detected_out;
		next_psp_cnt = psp_cnt;
		next_extra_cnt = extra_cnt;
		if (extra_pulse_in && extra_cnt != 4'hF) begin
			next_extra_cnt = extra_cnt + 4'h1;
		end
		if (vs_edge) begin
			next_extra_cnt = 4'h0;
			if (cp_ctrl[STRIPE_EN_BIT]) begin
				{next_stripe_det, next_stripe_cnt} =
					persist_step(stripe_detected_out, stripe_seen_in, stripe_cnt, need_fields);
			end
			if (cp_ctrl[PSP_EN_BIT]) begin
				{next_psp_det, next_psp_cnt} = persist_step(pseudo_sync_detected_out,
					psp_present, psp_cnt, need_fields);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			stripe_detected_out <= 1'b0;
			pseudo_sync_detected_out <= 1'b0;
			stripe_cnt <= 4'h0;
			psp_cnt <= 4'h0;
			extra_cnt <= 4'h0;
		end else begin
			stripe_detected_out <= next_stripe_det;
			pseudo_sync_detected_out <= next_psp_det;
			stripe_cnt <= next_stripe_cnt;
			psp_cnt <= next_psp_cnt;
			extra_cnt <= next_extra_cnt;
		end
	end

	// Checks on the behaviour above.
	sequence field_start_s;
		vsync_in && !vsync_prev;
	endsequence

	sequence stray_sync_s;
		hs_edge && !in_window;
	endsequence

	AST_RESET_VALUES: assert property (@(posedge clk_in)
		$past(reset_in) |-> vblank_end == 8'h12 && lsync_end == 8'h30 && window == 8'h20)
		else $error("Register reset values are wrong.");
	AST_WRITE_END_LINE: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_write_in && reg_addr_in == 8'h35 |=> vblank_end == $past(reg_wdata_in))
		else $error("End line register did not take the write.");
	AST_SYNC_WIDTH: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(!reset_in) |-> line_sync_out == ($past(next_hcount) < {2'b00, $past(lsync_end), 1'b0}))
		else $error("Line sync width does not match twice the end count.");
	AST_SYNC_LEAD: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(!reset_in) && hcount == 11'h000 && lsync_end != 8'h00 |-> line_sync_out)
		else $error("Line sync not high at count zero.");
	AST_LOCK_KEEP: assert property (@(posedge clk_in) disable iff (reset_in)
		hs_edge && in_window |=> !acquiring_out)
		else $error("Sync inside the window did not keep lock.");
	AST_ACQUIRE: assert property (@(posedge clk_in) disable iff (reset_in)
		stray_sync_s |=> acquiring_out && hcount == 11'h000
			&& acquire_mode_out == $past(lock_mode_in))
		else $error("Stray sync did not start acquisition.");
	AST_VBLANK_END: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(!reset_in) && line_num == $past(end_tgt) && $past(end_tgt) == end_tgt
			|-> !vblank_out)
		else $error("Vertical blanking not negated on its end line.");
	AST_STRIPE_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 !cp_ctrl[STRIPE_EN_BIT] |=> $stable(stripe_detected_out))
		else $error("Stripe status moved while disabled.");
	AST_PSP_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 !cp_ctrl[PSP_EN_BIT] |=> $stable(pseudo_sync_detected_out))
		else $error("Pseudo-sync status moved while disabled.");
	AST_PSP_NEEDS_PULSES: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 !pseudo_sync_detected_out && !psp_present |=> !pseudo_sync_detected_out)
		else $error("Pseudo-sync declared without enough extra pulses.");
	AST_FIELD_PERSIST: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 cp_ctrl[STRIPE_EN_BIT] && stripe_seen_in != stripe_detected_out
			&& stripe_cnt + 4'h1 < need_fields |=> $stable(stripe_detected_out))
		else $error("Stripe status changed before the field count.");
	// Reset defaults of the qualification fields, write paths, read-back, blanking start, odd offset, declaration and pulse clearing.
	AST_RESET_PSP_COUNT: assert property (@(posedge clk_in)
		$past(reset_in) |-> cp_ctrl[PSP_COUNT_LSB +: 3] == 3'h4)
		else $error("Extra pulse count field has the wrong reset value.");
	AST_RESET_FIELD_COUNT: assert property (@(posedge clk_in)
		$past(reset_in) |-> cp_ctrl[FIELD_COUNT_LSB +: 3] == 3'h6)
		else $error("Field count has the wrong reset value.");
	AST_WRITE_SYNC_END: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_write_in && reg_addr_in == LSYNC_END_ADDR |=> lsync_end == $past(reg_wdata_in))
		else $error("Line sync end register did not take the write.");
	AST_WRITE_WINDOW: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_write_in && reg_addr_in == WINDOW_ADDR |=> window == $past(reg_wdata_in))
		else $error("Window register did not take the write.");
	AST_READ_WINDOW: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_read_in && reg_addr_in == WINDOW_ADDR |=> reg_rvalid_out && reg_rdata_out == $past(window))
		else $error("Window register read-back is wrong.");
	AST_VBLANK_START: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(!reset_in) && line_num == $past(start_tgt) && $past(start_tgt) == start_tgt
			&& line_num != $past(end_tgt) |-> vblank_out)
		else $error("Vertical blanking not asserted on its start line.");
	AST_ODD_OFFSET: assert property (@(posedge clk_in) disable iff (reset_in)
		odd_field_in |-> off == 10'h005)
		else $error("Odd field blanking offset is wrong.");
	AST_PSP_DECLARE: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 !pseudo_sync_detected_out && psp_cnt + 4'h1 < need_fields |=> !pseudo_sync_detected_out)
		else $error("Pseudo-sync declared before the field count.");
	AST_STRIPE_DECLARE: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s ##0 cp_ctrl[STRIPE_EN_BIT] && stripe_seen_in && stripe_cnt + 4'h1 >= need_fields
			|=> stripe_detected_out)
		else $error("Stripe not declared after the field count.");
	AST_EXTRA_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in)
		field_start_s |=> extra_cnt == 4'h0)
		else $error("Extra pulse count not cleared at the field start.");
endmodule

// ### verif/host_model.sv
// Host model that programs the bank through its one-cycle strobe bus.
module host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic write_out,
	output logic read_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// The bus idles from time zero so nothing is taken during reset.
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		write_out = 1'b0;
		read_out = 1'b0;
	end
	// A write is one strobe cycle with address and data held until it is taken.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		write_out <= 1'b1;
		@(posedge clk_in);
		write_out <= 1'b0;
	endtask
	// Reads wait a bounded time; a missing answer leaves the result unknown.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		d = 8'hXX;
		@(posedge clk_in);
		addr_out <= a;
		read_out <= 1'b1;
		@(posedge clk_in);
		read_out <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_in);
			if (rvalid_in === 1'b1) begin
				d = rdata_in;
				break;
			end
		end
	endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the sync timing and copy-protection bank.
module tb;
	import sync_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, reset_in, hsync, vsync, odd_field, lines_625, stripe_seen, extra_pulse;
	logic [8:0] vblank_start;
	logic [1:0] lock_mode, acq_mode, mode_s;
	logic [7:0] addr, wdata, rdata, rd;
	logic write, read, rvalid, line_sync, vblank, acquiring, stripe_det, psp_det, acq_s, ls_s;
	int fail_count = 0;
	int comparisons = 0;
	int highs, t_rise, t_fall;
	sync_cfg uut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(write), .reg_read_in(read), .hsync_in(hsync),
		.vsync_in(vsync), .odd_field_in(odd_field), .lines_625_in(lines_625),
		.vblank_start_line_in(vblank_start), .lock_mode_in(lock_mode),
		.stripe_seen_in(stripe_seen), .extra_pulse_in(extra_pulse),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .line_sync_out(line_sync),
		.vblank_out(vblank), .acquiring_out(acquiring), .acquire_mode_out(acq_mode),
		.stripe_detected_out(stripe_det), .pseudo_sync_detected_out(psp_det));
	host_model host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
		.wdata_out(wdata), .write_out(write), .read_out(read));
	// The 50 MHz clock.
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// Counts every comparison and reports a mismatch at once.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Pulses the sync input, samples status two cycles on, counts line sync for g-2 cycles.
	task automatic sync_line(input int g);
		highs = 0;
		@(posedge clk_in);
		hsync <= 1'b1;
		@(posedge clk_in);
		hsync <= 1'b0;
		for (int i = 0; i < g - 2; i++) begin
			@(negedge clk_in);
			highs += int'(line_sync === 1'b1);
			if (i == 2) begin
				acq_s = acquiring;
				mode_s = acq_mode;
				ls_s = line_sync;
			end
		end
	endtask
	// One field: extra sync pulses, then the stripe flag with the vertical sync edge.
	task automatic field(input logic s, input int extras);
		repeat (extras) begin
			@(posedge clk_in);
			extra_pulse <= 1'b1;
			@(posedge clk_in);
			extra_pulse <= 1'b0;
		end
		@(posedge clk_in);
		stripe_seen <= s;
		vsync <= 1'b1;
		@(posedge clk_in);
		vsync <= 1'b0;
		repeat (3) @(negedge clk_in);
	endtask
	// Cuts a hang short; the tests need under half this span.
	initial begin
		repeat (60000) @(posedge clk_in);
		fail_count++;
		print_verdict();
	end
	// Main sequence.
	initial begin
		reset_in = 1'b1;
		{hsync, vsync, stripe_seen, extra_pulse, lines_625} = 5'h00;
		odd_field = 1'b1;
		vblank_start = 9'h002;
		lock_mode = 2'b01;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		host.read_reg(VBLANK_END_ADDR, rd);
		check(rd, 8'h12);
		host.read_reg(LSYNC_END_ADDR, rd);
		check(rd, 8'h30);
		host.read_reg(WINDOW_ADDR, rd);
		check(rd, 8'h20);
		host.read_reg(CP_CTRL_ADDR, rd);
		check(rd, 8'h26);
		host.read_reg(8'h40, rd);
		check(rd, 8'h00);
		host.write_reg(WINDOW_ADDR, 8'h90);
		host.write_reg(LSYNC_END_ADDR, 8'h04);
		host.read_reg(WINDOW_ADDR, rd);
		check(rd, 8'h90);
		// The first sync lands mid-line, far outside the window.
		repeat (800) @(posedge clk_in);
		sync_line(1716);
		check(acq_s, 8'h01);
		check(mode_s, 8'h01);
		check(ls_s, 8'h01);
		check(8'(highs), 8'h08);
		lock_mode <= 2'b10;
		sync_line(1616);
		check(acq_s, 8'h00);
		sync_line(1976);
		check(acq_s, 8'h00);
		sync_line(100);
		check(acq_s, 8'h01);
		check(mode_s, 8'h02);
		// Odd field: blanking from line 7 to line 9.
		lines_625 <= 1'b1;
		host.write_reg(VBLANK_END_ADDR, 8'h04);
		field(1'b0, 0);
		t_rise = -1;
		t_fall = -1;
		for (int i = 0; i < 16000 && t_fall < 0; i++) begin
			@(negedge clk_in);
			if (vblank === 1'b1 && t_rise < 0) t_rise = i;
			if (vblank !== 1'b1 && t_rise >= 0) t_fall = i;
		end
		check(8'(t_rise >= 8570 && t_rise <= 10300), 8'h01);
		check(8'(t_fall - t_rise >= 3431 && t_fall - t_rise <= 3433), 8'h01);
		// Copy-protection qualification.
		host.write_reg(CP_CTRL_ADDR, 8'h00);
		repeat (3) field(1'b1, 5);
		check({stripe_det, psp_det}, 8'h00);
		host.write_reg(CP_CTRL_ADDR, 8'hD0);
		field(1'b1, 1);
		check(stripe_det, 8'h00);
		field(1'b1, 1);
		check({stripe_det, psp_det}, 8'h02);
		field(1'b1, 2);
		check(psp_det, 8'h00);
		field(1'b1, 2);
		check(psp_det, 8'h01);
		host.write_reg(CP_CTRL_ADDR, 8'h00);
		repeat (3) field(1'b0, 0);
		check({stripe_det, psp_det}, 8'h03);
		print_verdict();
	end
endmodule
